/* inc/cmb_pkg.sv */
// constants shared by the can message buffering block
package cmb_pkg;
  // ------------------------------------------------------------
  // message buffer geometry
  // ------------------------------------------------------------
  localparam int unsigned CMB_BYTES   = 13;      // bytes per buffer
  localparam int unsigned CMB_BUF_W   = 104;     // 13 bytes flattened
  localparam int unsigned CMB_NTX     = 3;       // transmit buffers
  localparam int unsigned CMB_LOCAL_PRIORITY_FIELD_W  = 8;       // local priority width
  localparam logic [3:0]  CMB_IDX_MAX = 4'hc;    // last byte index

  // ------------------------------------------------------------
  // register map (byte addresses, 8-bit data)
  // ------------------------------------------------------------
  localparam logic [3:0] CMB_PG_FOREGROUND_RX_BUFFER  = 4'h0;    // page: rx window
  localparam logic [3:0] CMB_PG_CTRL  = 4'h1;    // page: flags/control
  localparam logic [3:0] CMB_PG_TXB0  = 4'h2;    // page: tx buffer 0
  localparam logic [3:0] CMB_PG_TXB2  = 4'h4;    // page: tx buffer 2
  localparam logic [3:0] CMB_OFS_LOCAL_PRIORITY_FIELD = 4'hd;    // priority in tx page
  localparam logic [3:0] CMB_OFS_RXF  = 4'h0;    // receiver_flag_reg
  localparam logic [3:0] CMB_OFS_RXIE = 4'h1;    // rx interrupt enables
  localparam logic [3:0] CMB_OFS_TXF  = 4'h2;    // transmitter_flag_reg
  localparam logic [3:0] CMB_OFS_TXC  = 4'h3;    // tx_control_reg
  localparam logic [3:0] CMB_OFS_MODE = 4'h4;    // mode register

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int unsigned CMB_B_RXFULL = 0;      // rx_full_flag
  localparam int unsigned CMB_B_OVR    = 1;      // overrun flag
  localparam int unsigned CMB_B_LOOP   = 0;      // loop-back enable
  localparam int unsigned CMB_F_HI_LSB = 4;      // upper nibble field

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] CMB_RST_BYTE  = 8'h00;
  localparam logic [2:0] CMB_RST_EMPTY = 3'h7;   // all tx buffers free
  localparam logic [1:0] CMB_TXSEL_0   = 2'h0;
  localparam logic       CMB_RECESSIVE = 1'b1;   // pin level, recessive
endpackage : cmb_pkg

/* rtl/cmb_pin_sync.sv */
// three-stage pin synchroniser with agreement of the last two stages
`timescale 1ns/1ps
`default_nettype none
module cmb_pin_sync
  import cmb_pkg::*;
#(
  parameter logic RST_VAL = 1'b1               // idle level of the pin
) (
  input  wire logic clock_i,                   // module clock
  input  wire logic arst_n_i,                  // async reset, active low
  input  wire logic pin_i,                     // raw asynchronous pin
  output logic      level_o                    // filtered level
);
  // ------------------------------------------------------------
  // stages
  // ------------------------------------------------------------
  logic s1_q;                                  // metastable catcher only
  logic s2_q;                                  // second stage
  logic s3_q;                                  // third stage
  logic lvl_q;                                 // accepted level

  // a change is taken only once stages two and three agree
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_q  <= RST_VAL;
      s2_q  <= RST_VAL;
      s3_q  <= RST_VAL;
      lvl_q <= RST_VAL;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        lvl_q <= s3_q;
      end
    end
  end

  assign level_o = lvl_q;
endmodule : cmb_pin_sync
`default_nettype wire

/* rtl/cmb_msg_buf.sv */
// one 13-byte message buffer: byte write, whole-buffer load, byte read
`timescale 1ns/1ps
`default_nettype none
module cmb_msg_buf
  import cmb_pkg::*;
(
  input  wire logic                 clock_i,    // module clock
  input  wire logic                 arst_n_i,   // async reset, active low
  input  wire logic                 wr_en_i,    // byte write strobe
  input  wire logic [3:0]           wr_idx_i,   // byte index
  input  wire logic [7:0]           wr_data_i,  // byte value
  input  wire logic                 load_i,     // load whole buffer
  input  wire logic [CMB_BUF_W-1:0] load_i_data,// flattened image in
  input  wire logic [3:0]           rd_idx_i,   // byte index to read
  output logic      [7:0]           rd_data_o,  // selected byte
  output logic      [CMB_BUF_W-1:0] image_o     // flattened image out
);
  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [7:0] mem_q [CMB_BYTES];               // byte cells

  // whole-buffer load has priority over a single byte write
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < CMB_BYTES; i++) begin
        mem_q[i] <= CMB_RST_BYTE;
      end
    end else if (load_i) begin
      for (int i = 0; i < CMB_BYTES; i++) begin
        mem_q[i] <= load_i_data[i*8 +: 8];
      end
    end else if (wr_en_i && (wr_idx_i <= CMB_IDX_MAX)) begin
      mem_q[wr_idx_i] <= wr_data_i;
    end
  end

  // read mux; out-of-range indices read as zero
  assign rd_data_o = (rd_idx_i <= CMB_IDX_MAX) ? mem_q[rd_idx_i]
                                               : CMB_RST_BYTE;

  for (genvar g = 0; g < CMB_BYTES; g++) begin : g_img
    assign image_o[g*8 +: 8] = mem_q[g];
  end
endmodule : cmb_msg_buf
`default_nettype wire

/* rtl/cmb_msg_store.sv */
// message storage of a can controller: rx fifo and tx buffer scheduling
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module cmb_msg_store
  import cmb_pkg::*;
(
  input  wire logic       clock_i,              // 125 MHz module clock
  input  wire logic       arst_n_i,             // async reset, active low
  // register port
  input  wire logic [7:0] reg_addr_i,           // byte address
  input  wire logic [7:0] reg_wdata_i,          // write data
  input  wire logic       reg_wr_i,             // write strobe
  input  wire logic       reg_rd_i,             // read strobe
  output logic      [7:0] reg_rdata_o,          // read data, next cycle
  // can pins
  input  wire logic       can_receive_pin_i,    // bus level, async
  output logic            can_transmit_pin_o,   // bus level driven
  // bit engine side, receive
  output logic            rx_bit_dominant_o,    // synchronised rx level, inverted: high when dominant
  input  wire logic       rx_byte_we_i,         // byte of current frame
  input  wire logic [3:0] rx_byte_idx_i,        // its position
  input  wire logic [7:0] rx_byte_i,            // its value
  input  wire logic       rx_frame_ok_i,        // frame ended correctly
  input  wire logic       rx_accept_i,          // filter hit, with ok
  output logic            ack_enable_o,         // may acknowledge frame
  // bit engine side, transmit
  input  wire logic       tx_dominant_i,        // engine drives dominant
  input  wire logic       arb_start_i,          // arbitration begins
  input  wire logic       arb_lost_i,           // arbitration lost
  input  wire logic       tx_error_i,           // transmission error
  input  wire logic       tx_done_i,            // frame sent successfully
  output logic            tx_busy_o,            // a buffer is on the bus
  output logic      [1:0] tx_sel_o,             // buffer being sent
  input  wire logic [3:0] tx_byte_idx_i,        // byte wanted by engine
  output logic      [7:0] tx_byte_o,            // that byte, next cycle
  // interrupt requests
  output logic            rx_irq_o,             // receive interrupt
  output logic            err_irq_o,            // overrun interrupt
  output logic            tx_irq_o              // transmit interrupt
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic                  rx_full_q;        // rx_full_flag
  logic                  ovr_q;            // overrun flag
  logic                  bg_pend_q;        // background holds a frame
  logic [1:0]            rxie_q;           // rx interrupt enables
  logic [2:0]            empty_q;          // tx_empty_flag per buffer
  logic [2:0]            txie_q;           // tx interrupt enables
  logic [2:0]            abrq_q;           // abort_request_flag
  logic [2:0]            abak_q;           // abort_ack_flag
  logic                  loop_q;           // loop-back mode
  logic [CMB_LOCAL_PRIORITY_FIELD_W-1:0] local_priority_field_q [CMB_NTX]; // local_priority_field
  logic                  busy_q;           // transmitting a buffer
  logic [1:0]            sel_q;            // buffer under transmission
  logic [7:0]            rdata_q;          // registered read data
  logic [7:0]            txb_q;            // registered engine byte
  logic                  txpin_q;          // registered pin level

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------
  wire [3:0] pg      = reg_addr_i[7:4];     // page
  wire [3:0] ofs     = reg_addr_i[3:0];     // offset in page
  wire       pg_rx   = (pg == CMB_PG_FOREGROUND_RX_BUFFER);
  wire       pg_ctl  = (pg == CMB_PG_CTRL);
  wire       pg_tx   = (pg >= CMB_PG_TXB0) && (pg <= CMB_PG_TXB2);
  wire [1:0] host_n  = 2'(pg - CMB_PG_TXB0);   // addressed tx buffer
  wire       is_local_priority_field = pg_tx && (ofs == CMB_OFS_LOCAL_PRIORITY_FIELD);
  wire       wr_ctl  = reg_wr_i && pg_ctl;
  wire       w_rxf   = wr_ctl && (ofs == CMB_OFS_RXF);
  wire       w_rxie  = wr_ctl && (ofs == CMB_OFS_RXIE);
  wire       w_txf   = wr_ctl && (ofs == CMB_OFS_TXF);
  wire       w_txc   = wr_ctl && (ofs == CMB_OFS_TXC);
  wire       w_mode  = wr_ctl && (ofs == CMB_OFS_MODE);
  wire       w_txb   = reg_wr_i && pg_tx && !is_local_priority_field;
  wire       w_local_priority_field  = reg_wr_i && is_local_priority_field;

  // ------------------------------------------------------------
  // receive side decisions
  // ------------------------------------------------------------
  // own frame unless loop-back makes it an ordinary one
  wire own_frame  = busy_q && !loop_q;
  wire acc_done   = rx_frame_ok_i && rx_accept_i && !own_frame;
  // background locked while it keeps a frame for the foreground
  wire bg_wr      = rx_byte_we_i && !bg_pend_q;
  // accepted frame landing in a free foreground
  wire copy_new   = acc_done && !bg_pend_q && !rx_full_q;
  // queued frame moves once the host has freed the foreground
  wire copy_pend  = bg_pend_q && !rx_full_q;
  wire fg_load    = copy_new || copy_pend;
  wire queue_new  = acc_done && !bg_pend_q && rx_full_q;
  wire overrun    = acc_done && bg_pend_q;
  // host clear of rx full, ignored while a copy sets it
  wire clr_rxf    = w_rxf && reg_wdata_i[CMB_B_RXFULL];
  wire clr_ovr    = w_rxf && reg_wdata_i[CMB_B_OVR];

  // ------------------------------------------------------------
  // message buffers
  // ------------------------------------------------------------
  logic [CMB_BUF_W-1:0] bg_img;            // background image
  logic [7:0]           fg_byte;           // host byte from foreground
  logic [7:0]           tx_host_byte [CMB_NTX];  // host readback
  logic [7:0]           tx_eng_byte  [CMB_NTX];  // engine readout

  // background buffer, written only by the receive engine
  cmb_msg_buf u_bg (
    .clock_i     (clock_i),
    .arst_n_i    (arst_n_i),
    .wr_en_i     (bg_wr),
    .wr_idx_i    (rx_byte_idx_i),
    .wr_data_i   (rx_byte_i),
    .load_i      (1'b0),
    .load_i_data ({CMB_BUF_W{1'b0}}),
    .rd_idx_i    (4'h0),
    .rd_data_o   (),
    .image_o     (bg_img)
  );

  // foreground buffer, loaded whole from the background
  cmb_msg_buf u_fg (
    .clock_i     (clock_i),
    .arst_n_i    (arst_n_i),
    .wr_en_i     (1'b0),
    .wr_idx_i    (4'h0),
    .wr_data_i   (8'h00),
    .load_i      (fg_load),
    .load_i_data (bg_img),
    .rd_idx_i    (ofs),
    .rd_data_o   (fg_byte),
    .image_o     ()
  );

  // three transmit buffers, host written, engine and host read
  for (genvar n = 0; n < CMB_NTX; n++) begin : g_txb
    // writes to the buffer on the bus are dropped to keep it stable
    wire wr_n = w_txb && (host_n == 2'(n)) && !(busy_q && sel_q == 2'(n));
    logic [CMB_BUF_W-1:0] img_n;           // flattened image for engine
    cmb_msg_buf u_tx (
      .clock_i     (clock_i),
      .arst_n_i    (arst_n_i),
      .wr_en_i     (wr_n),
      .wr_idx_i    (ofs),
      .wr_data_i   (reg_wdata_i),
      .load_i      (1'b0),
      .load_i_data ({CMB_BUF_W{1'b0}}),
      .rd_idx_i    (ofs),
      .rd_data_o   (tx_host_byte[n]),
      .image_o     (img_n)
    );
    // engine readout: own index, independent of the host address
    assign tx_eng_byte[n] = (tx_byte_idx_i <= CMB_IDX_MAX)
                            ? img_n[tx_byte_idx_i*8 +: 8] : CMB_RST_BYTE;
  end

  // ------------------------------------------------------------
  // transmit scheduling
  // ------------------------------------------------------------
  logic [1:0] best_n;                      // chosen buffer
  logic       any_rdy;                     // a buffer is ready
  logic [2:0] ready;                       // scheduled and not aborted

  assign ready = ~empty_q;

  // lowest value wins; strict compare keeps the lower index on a tie
  always_comb begin
    logic [CMB_LOCAL_PRIORITY_FIELD_W-1:0] best_p;
    best_p  = '1;
    best_n  = CMB_TXSEL_0;
    any_rdy = 1'b0;
    for (int i = 0; i < CMB_NTX; i++) begin
      if (ready[i] && (!any_rdy || local_priority_field_q[i] < best_p)) begin
        best_p  = local_priority_field_q[i];
        best_n  = 2'(i);
        any_rdy = 1'b1;
      end
    end
  end

  // abort is granted only to a ready buffer not on the bus
  logic [2:0] on_bus;                      // one-hot of buffer sent
  logic [2:0] abort_ok;                    // abort granted now
  logic [2:0] sent;                        // successful completion
  logic [2:0] clr_empty;                   // host marks ready

  always_comb begin
    for (int i = 0; i < CMB_NTX; i++) begin
      on_bus[i]    = busy_q && (sel_q == 2'(i));
      sent[i]      = on_bus[i] && tx_done_i;
      abort_ok[i]  = abrq_q[i] && ready[i] && !on_bus[i];
      // clear ignored while the buffer is still being released
      clr_empty[i] = w_txf && reg_wdata_i[i] && !sent[i]
                     && !abort_ok[i];
    end
  end

  // selection happens at every arbitration, errors included
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_q <= 1'b0;
      sel_q  <= CMB_TXSEL_0;
    end else if (arb_start_i) begin
      busy_q <= any_rdy;
      sel_q  <= best_n;
    end else if (tx_done_i || tx_error_i || arb_lost_i) begin
      busy_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // transmit flags and control
  // ------------------------------------------------------------
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      empty_q <= CMB_RST_EMPTY;
      abak_q  <= 3'h0;
      abrq_q  <= 3'h0;
      txie_q  <= 3'h0;
    end else begin
      for (int i = 0; i < CMB_NTX; i++) begin
        if (sent[i] || abort_ok[i]) begin
          empty_q[i] <= 1'b1;
          abrq_q[i]  <= 1'b0;
          abak_q[i]  <= abort_ok[i];
        end else if (clr_empty[i]) begin
          empty_q[i] <= 1'b0;
          abak_q[i]  <= 1'b0;
        end else if (w_txc) begin
          abrq_q[i] <= reg_wdata_i[CMB_F_HI_LSB + i] && ready[i];
        end
      end
      if (w_txc) begin
        txie_q <= reg_wdata_i[2:0];
      end
    end
  end

  // priorities, written by the host at any time
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < CMB_NTX; i++) begin
        local_priority_field_q[i] <= CMB_RST_BYTE;
      end
    end else if (w_local_priority_field) begin
      local_priority_field_q[host_n] <= reg_wdata_i;
    end
  end

  // ------------------------------------------------------------
  // receive flags
  // ------------------------------------------------------------
  // a set in the same cycle as a host clear always wins
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_full_q <= 1'b0;
      bg_pend_q <= 1'b0;
      ovr_q     <= 1'b0;
    end else begin
      if (fg_load) begin
        rx_full_q <= 1'b1;
      end else if (clr_rxf) begin
        rx_full_q <= 1'b0;
      end
      if (queue_new) begin
        bg_pend_q <= 1'b1;
      end else if (copy_pend) begin
        bg_pend_q <= 1'b0;
      end
      if (overrun) begin
        ovr_q <= 1'b1;
      end else if (clr_ovr) begin
        ovr_q <= 1'b0;
      end
    end
  end

  // enables and mode
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rxie_q <= 2'h0;
      loop_q <= 1'b0;
    end else begin
      if (w_rxie) begin
        rxie_q <= reg_wdata_i[1:0];
      end
      if (w_mode) begin
        loop_q <= reg_wdata_i[CMB_B_LOOP];
      end
    end
  end

  // ------------------------------------------------------------
  // read path: data stand only in the cycle after the strobe
  // ------------------------------------------------------------
  logic [7:0] ctl_byte;                    // control page mux
  always_comb begin
    case (ofs)
      CMB_OFS_RXF:  ctl_byte = {6'h00, ovr_q, rx_full_q};
      CMB_OFS_RXIE: ctl_byte = {6'h00, rxie_q};
      CMB_OFS_TXF:  ctl_byte = {1'b0, abak_q, 1'b0, empty_q};
      CMB_OFS_TXC:  ctl_byte = {1'b0, abrq_q, 1'b0, txie_q};
      CMB_OFS_MODE: ctl_byte = {7'h00, loop_q};
      default:      ctl_byte = 8'h00;
    endcase
  end

  wire [7:0] rd_mux = pg_rx   ? fg_byte
                    : pg_ctl  ? ctl_byte
                    : is_local_priority_field ? local_priority_field_q[host_n]
                    : pg_tx   ? tx_host_byte[host_n]
                    : 8'h00;                           // unmapped

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd_i ? rd_mux : 8'h00;
    end
  end

  // ------------------------------------------------------------
  // engine byte readout and pins
  // ------------------------------------------------------------
  // the engine reads the selected buffer at its own byte index;
  // registered so the byte stands one cycle after the index
  logic [7:0] eng_byte;
  assign eng_byte = tx_eng_byte[sel_q];

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      txb_q   <= 8'h00;
      txpin_q <= CMB_RECESSIVE;
    end else begin
      txb_q   <= eng_byte;
      // dominant from the engine drives the pin low
      txpin_q <= ~tx_dominant_i;
    end
  end

  logic rx_level;                          // synchronised pin level
  cmb_pin_sync #(
    .RST_VAL (CMB_RECESSIVE)
  ) u_rx_sync (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .pin_i    (can_receive_pin_i),
    .level_o  (rx_level)
  );

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign reg_rdata_o        = rdata_q;
  assign can_transmit_pin_o = txpin_q;
  assign rx_bit_dominant_o  = ~rx_level;
  assign ack_enable_o       = !own_frame;
  assign tx_busy_o          = busy_q;
  assign tx_sel_o           = sel_q;
  assign tx_byte_o          = txb_q;
  assign rx_irq_o  = rx_full_q && rxie_q[CMB_B_RXFULL];
  assign err_irq_o = ovr_q && rxie_q[CMB_B_OVR];
  assign tx_irq_o  = |(empty_q & txie_q);
endmodule : cmb_msg_store
`default_nettype wire

/* tb/cmb_msg_store_properties.sv */
// checker on the message store ports
`timescale 1ns/1ps
`default_nettype none
module cmb_chk (
  input wire logic       clock_i, arst_n_i, reg_rd_i, reg_wr_i,
  input wire logic       tx_dominant_i, can_transmit_pin_o,
  input wire logic       tx_done_i, arb_start_i, tx_busy_o,
  input wire logic       rx_frame_ok_i, ack_enable_o,
  input wire logic       rx_irq_o, err_irq_o,
  input wire logic [1:0] tx_sel_o,
  input wire logic [7:0] reg_rdata_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  a_pin_dom: assert property (
    tx_dominant_i |=> !can_transmit_pin_o) else $error("no dominant");
  a_rd_idle: assert property (
    !reg_rd_i |=> reg_rdata_o == 8'h00) else $error("stray data");
  a_done_idle: assert property (
    tx_done_i |=> !tx_busy_o) else $error("busy after done");
  a_busy_arb: assert property (
    $rose(tx_busy_o) |-> $past(arb_start_i)) else $error("busy cause");
  a_sel_hold: assert property (
    tx_busy_o && $past(tx_busy_o) |-> $stable(tx_sel_o))
    else $error("sel moved");
  a_ack_idle: assert property (
    !tx_busy_o |-> ack_enable_o) else $error("ack blocked");
  a_ovr_cause: assert property (
    $rose(err_irq_o) |-> $past(rx_frame_ok_i) || $past(reg_wr_i))
    else $error("overrun cause");
  a_rx_cause: assert property (
    $rose(rx_irq_o) |-> $past(rx_frame_ok_i) || $past(reg_wr_i)
    || $past(reg_wr_i, 2) || $past(reg_wr_i, 3)) else $error("rx cause");
  c_rx: cover property ($rose(rx_irq_o));
  c_ovr: cover property ($rose(err_irq_o));
  c_done: cover property (tx_done_i && tx_busy_o);
endmodule : cmb_chk
bind cmb_msg_store cmb_chk i_chk (.*);
`default_nettype wire

/* tb/cmb_bus_model.sv */
// bus model: the dut and one other node on a wired-and line
`timescale 1ns/1ps
`default_nettype none
module cmb_bus_model (
  input  wire logic node_tx_i,  // dut pin, 0 dominant
  input  wire logic other_tx_i, // other node, idle recessive
  output logic      bus_o       // level seen by every node
);
  // dominant wins, so any node at 0 pulls the line low
  assign bus_o = node_tx_i & other_tx_i;
endmodule : cmb_bus_model
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the can message store
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cmb_pkg::*;
  logic clock_i = 0, arst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic [7:0] reg_addr_i = '0, reg_wdata_i = '0, rx_byte_i = '0;
  logic [3:0] rx_byte_idx_i = '0, tx_byte_idx_i = '0, ev = '0;
  logic rx_byte_we_i = 0, rx_frame_ok_i = 0, rx_accept_i = 0;
  logic tx_dominant_i = 0, other_tx = 1;
  wire logic arb_start_i, tx_done_i, tx_error_i, arb_lost_i;
  wire logic can_receive_pin_i;
  logic [7:0] reg_rdata_o, tx_byte_o;
  logic [1:0] tx_sel_o;
  logic can_transmit_pin_o, rx_bit_dominant_o, ack_enable_o;
  logic tx_busy_o, rx_irq_o, err_irq_o, tx_irq_o;
  int error_cnt = 0, cmp_count = 0;
  assign {arb_start_i, tx_done_i, tx_error_i, arb_lost_i} = ev;
  always #4 clock_i = ~clock_i;
  cmb_msg_store i_dut (.*);
  cmb_bus_model i_bus (.node_tx_i(can_transmit_pin_o),
    .other_tx_i(other_tx), .bus_o(can_receive_pin_i));
  task automatic chk(input string n, input logic [7:0] s, e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    @(posedge clock_i);
    {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, e, input string n);
    @(posedge clock_i);
    {reg_rd_i, reg_addr_i} <= {1'b1, a};
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1 chk(n, reg_rdata_o, e);
  endtask : rd
  // engine side pulse on arb/done/error/lost, then settle
  task automatic pulse(input logic [3:0] v);
    @(posedge clock_i) ev <= v;
    @(posedge clock_i) ev <= '0;
    @(posedge clock_i) #1;
  endtask : pulse
  task automatic frame(input logic [7:0] b);
    for (int i = 0; i < CMB_BYTES; i++) begin
      @(posedge clock_i);
      {rx_byte_we_i, rx_byte_idx_i, rx_byte_i} <= {1'b1, 4'(i), b + 8'(i)};
    end
    @(posedge clock_i);
    {rx_byte_we_i, rx_frame_ok_i, rx_accept_i} <= 3'b011;
    @(posedge clock_i);
    {rx_frame_ok_i, rx_accept_i} <= 2'b00;
    repeat (2) @(posedge clock_i);
  endtask : frame
  task automatic stop_test;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  // watchdog: the run needs a few hundred cycles at most
  initial begin
    #80000;
    error_cnt++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge clock_i);
    arst_n_i <= 1'b1;
    rd(8'h12, 8'h07, "empty");
    wr(8'h11, 8'h03);
    frame(8'h10);
    rd(8'h10, 8'h01, "rxfull");
    rd(8'h0c, 8'h1c, "last");
    frame(8'h40);
    frame(8'h80);
    rd(8'h10, 8'h03, "ovr");
    chk("errirq", 8'(err_irq_o), 8'h01);
    rd(8'h00, 8'h10, "kept");
    wr(8'h10, 8'h03);
    repeat (3) @(posedge clock_i);
    rd(8'h00, 8'h40, "fifo");
    chk("rxirq", 8'(rx_irq_o), 8'h01);
    @(posedge clock_i) tx_dominant_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    chk("pin", {6'h00, can_transmit_pin_o, rx_bit_dominant_o}, 8'h01);
    tx_dominant_i <= 1'b0;
    wr(8'h2d, 8'h05);
    wr(8'h23, 8'h5a);
    wr(8'h3d, 8'h02);
    wr(8'h4d, 8'h02);
    wr(8'h13, 8'h07);
    wr(8'h12, 8'h07);
    pulse(4'h8);
    chk("tie", 8'(tx_sel_o), 8'h01);
    pulse(4'h1);
    wr(8'h4d, 8'h01);
    pulse(4'h8);
    chk("resel", 8'(tx_sel_o), 8'h02);
    pulse(4'h4);
    rd(8'h12, 8'h04, "sent");
    chk("txirq", 8'(tx_irq_o), 8'h01);
    pulse(4'h8);
    pulse(4'h2);
    pulse(4'h8);
    chk("afterr", 8'(tx_sel_o), 8'h01);
    pulse(4'h4);
    pulse(4'h8);
    chk("low", 8'(tx_sel_o), 8'h00);
    @(posedge clock_i) tx_byte_idx_i <= 4'h3;
    repeat (2) @(posedge clock_i);
    #1 chk("txbyte", tx_byte_o, 8'h5a);
    pulse(4'h4);
    rd(8'h12, 8'h07, "allsent");
    wr(8'h10, 8'h01);
    wr(8'h12, 8'h01);
    pulse(4'h8);
    chk("ackoff", 8'(ack_enable_o), 8'h00);
    frame(8'ha0);
    rd(8'h10, 8'h00, "ownfrm");
    pulse(4'h4);
    wr(8'h14, 8'h01);
    wr(8'h12, 8'h01);
    pulse(4'h8);
    frame(8'hc0);
    rd(8'h00, 8'hc0, "loop");
    pulse(4'h4);
    wr(8'h12, 8'h01);
    wr(8'h13, 8'h17);
    rd(8'h12, 8'h17, "abort");
    stop_test();
  end
endmodule : testbench
`default_nettype wire
